// file: design/tmrw_pkg.sv
// Shared constants, types and decode functions for the timer waveform control block
package tmrw_pkg;

  // Control register A: data-space offset, and the short I/O offset derived from it
  localparam logic [7:0] TMRW_CTRL_A_OFS   = 8'h44;
  localparam logic [7:0] TMRW_IO_SHIFT     = 8'h20;
  localparam logic [7:0] TMRW_CTRL_A_IO    = TMRW_CTRL_A_OFS - TMRW_IO_SHIFT;
  // Second control register, holding the top-select bit
  localparam logic [7:0] TMRW_CTRL_B_OFS   = 8'h45;
  localparam logic [7:0] TMRW_CTRL_B_IO    = TMRW_CTRL_B_OFS - TMRW_IO_SHIFT;

  // Field positions in control register A
  localparam int unsigned TMRW_CHA_HI_POS  = 7;
  localparam int unsigned TMRW_CHA_LO_POS  = 6;
  localparam int unsigned TMRW_CHB_HI_POS  = 5;
  localparam int unsigned TMRW_CHB_LO_POS  = 4;
  localparam int unsigned TMRW_WSEL_MID_POS = 1;
  localparam int unsigned TMRW_WSEL_LOW_POS = 0;
  // Field position in the second control register
  localparam int unsigned TMRW_TOPSEL_POS  = 3;

  // Implemented bits; the rest read as zero
  localparam logic [7:0] TMRW_CTRL_A_MASK  = 8'hF3;
  localparam logic [7:0] TMRW_CTRL_B_MASK  = 8'h08;
  localparam logic [7:0] TMRW_CTRL_A_RST   = 8'h00;
  localparam logic       TMRW_TOPSEL_RST   = 1'b0;

  // Counter limits
  localparam logic [7:0] TMRW_MAX          = 8'hFF;
  localparam logic [7:0] TMRW_BOTTOM       = 8'h00;
  localparam logic [7:0] TMRW_ONE          = 8'h01;

  // Output mode codes of a compare channel
  localparam logic [1:0] TMRW_COM_OFF      = 2'h0;
  localparam logic [1:0] TMRW_COM_TOGGLE   = 2'h1;
  localparam logic [1:0] TMRW_COM_CLEAR    = 2'h2;
  localparam logic [1:0] TMRW_COM_SET      = 2'h3;

  // Waveform select codes
  localparam logic [2:0] TMRW_WS_NORMAL    = 3'h0;
  localparam logic [2:0] TMRW_WS_PC_MAX    = 3'h1;
  localparam logic [2:0] TMRW_WS_CTC       = 3'h2;
  localparam logic [2:0] TMRW_WS_FAST_MAX  = 3'h3;
  localparam logic [2:0] TMRW_WS_PC_A      = 3'h5;
  localparam logic [2:0] TMRW_WS_FAST_A    = 3'h7;

  typedef enum logic [2:0] {
    TMRW_K_NORMAL,
    TMRW_K_CTC,
    TMRW_K_FAST,
    TMRW_K_PHASE,
    TMRW_K_RSVD
  } tmrw_kind_e;

  // Counting family of a waveform select code
  function automatic tmrw_kind_e tmrw_kind(input logic [2:0] sel);
    tmrw_kind_e k;
    case (sel)
      TMRW_WS_NORMAL:                 k = TMRW_K_NORMAL;
      TMRW_WS_CTC:                    k = TMRW_K_CTC;
      TMRW_WS_PC_MAX, TMRW_WS_PC_A:   k = TMRW_K_PHASE;
      TMRW_WS_FAST_MAX, TMRW_WS_FAST_A: k = TMRW_K_FAST;
      default:                        k = TMRW_K_RSVD;
    endcase
    return k;
  endfunction : tmrw_kind

  // High when compare value A is TOP for this select code
  function automatic logic tmrw_top_is_a(input logic [2:0] sel);
    return (sel == TMRW_WS_CTC) || (sel == TMRW_WS_PC_A) || (sel == TMRW_WS_FAST_A);
  endfunction : tmrw_top_is_a

endpackage : tmrw_pkg

// file: design/tmrw_oc_chan.sv
// One compare output channel: turns match, BOTTOM and TOP events into the output level
`timescale 1ns/100ps
`default_nettype none

module tmrw_oc_chan
  import tmrw_pkg::*;
#(
  parameter bit IS_CHAN_A = 1'b1      // Channel A may toggle in PWM families
) (
  input  wire logic       core_clk,   // Timer clock
  input  wire logic       rstn,       // Async reset, active low
  input  wire tmrw_kind_e kind,       // Counting family
  input  wire logic [1:0] com,        // Output mode field of this channel
  input  wire logic       top_sel,    // Top-select mode bit
  input  wire logic       match_ev,   // Compare match on this tick
  input  wire logic       bottom_ev,  // Fast PWM wrap from TOP to BOTTOM on this tick
  input  wire logic       top_ev,     // Phase-correct turn at TOP on this tick
  input  wire logic       up,         // Counting direction, high while counting up
  input  wire logic       ocr_is_top, // Compare value equals TOP
  output logic            out         // Compare output level
);

  typedef struct packed {
    logic out;
  } tmrw_chan_state_s;

  tmrw_chan_state_s s_q;
  tmrw_chan_state_s s_d;

  always_comb begin
    s_d = s_q;
    case (kind)
      TMRW_K_FAST: begin
        if (com == TMRW_COM_TOGGLE) begin
          if (IS_CHAN_A && top_sel && match_ev) begin
            s_d.out = ~s_q.out;
          end
        end else if (com[1]) begin
          // Match at TOP is dropped so only the BOTTOM action remains
          if (match_ev && !ocr_is_top) begin
            s_d.out = com[0];
          end
          if (bottom_ev) begin
            s_d.out = ~com[0];
          end
        end
      end
      TMRW_K_PHASE: begin
        if (com == TMRW_COM_TOGGLE) begin
          if (IS_CHAN_A && top_sel && match_ev) begin
            s_d.out = ~s_q.out;
          end
        end else if (com[1]) begin
          if (ocr_is_top) begin
            // Level at TOP equals a down-counting match result
            if (top_ev) begin
              s_d.out = ~com[0];
            end
          end else if (match_ev) begin
            s_d.out = up ? com[0] : ~com[0];
          end
        end
      end
      default: begin
        if (match_ev) begin
          case (com)
            TMRW_COM_TOGGLE: s_d.out = ~s_q.out;
            TMRW_COM_CLEAR:  s_d.out = 1'b0;
            TMRW_COM_SET:    s_d.out = 1'b1;
            default:         s_d.out = s_q.out;
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign out = s_q.out;

endmodule : tmrw_oc_chan

`default_nettype wire

// file: design/tmrw_wave_ctrl.sv
// Timer waveform mode control: control registers, counter sequencing and compare outputs
//
// Overview of operation
// - Fully synchronous; the timer tick is only an enable on the I/O clock.
// - An asynchronous instance clocks this logic from the timer oscillator instead.
// - Control register A at data offset 0x44, or 0x24 by short I/O access.
// - Nonzero output mode hands the pin to the compare output; software sets direction.
// - Non-PWM channel A bits 7:6: off, toggle, clear, set on compare match.
// - Non-PWM channel B bits 5:4: off, toggle, clear, set on compare match.
// - Fast PWM channel A: 10 clear on match, set at BOTTOM; 11 inverse.
// - PWM channel A code 01 toggles on match only with top-select bit set.
// - Fast PWM channel B: 10 clear/set at BOTTOM, 11 inverse; code 01 reserved.
// - Phase-correct channel A: 10 clears on up match, sets on down; 11 reverse.
// - Phase-correct channel B: 10 clears on up match, sets on down; 11 reverse.
// - Fast PWM: value A at TOP with high bit set ignores match, acts at BOTTOM.
// - Phase-correct: value A at TOP with high bit set ignores match, acts at TOP.
// - Value B at TOP with high bit set ignores match, acts at BOTTOM in fast PWM, at TOP in phase-correct.
// - Modes 0,1,3 TOP 0xFF; 2,5,7 TOP is value A; 4 and 6 reserved.
// - Compare update immediate, at TOP or BOTTOM; overflow at MAX, BOTTOM or TOP.
// - Low mode bits in register A bits 1:0; third bit in second register.
// - Fast PWM counts up to TOP, then returns to BOTTOM on the next tick.
// - Phase-correct reverses at TOP and holds TOP for exactly one tick.
`timescale 1ns/100ps
`default_nettype none

module tmrw_wave_ctrl
  import tmrw_pkg::*;
(
  input  wire logic       core_clk,          // I/O clock, or timer oscillator if asynchronous
  input  wire logic       rstn,              // Async reset, active low
  input  wire logic [7:0] io_addr,           // Register address
  input  wire logic       io_short,          // High: address is a short I/O address
  input  wire logic [7:0] io_wdata,          // Write data
  input  wire logic       io_wr,             // Write strobe, one cycle
  input  wire logic       io_rd,             // Read strobe, one cycle
  output logic      [7:0] io_rdata,          // Read data, valid the cycle after io_rd
  input  wire logic       timer_tick_enable, // Prescaled tick, same clock domain
  input  wire logic [7:0] compare_value_a,   // Compare value A as written by software
  input  wire logic [7:0] compare_value_b,   // Compare value B as written by software
  output logic      [7:0] count_value,       // Counter value
  output logic            overflow_flag,     // Overflow event pulse
  output logic            compare_flag_a,    // Compare match A event pulse
  output logic            compare_flag_b,    // Compare match B event pulse
  output logic            compare_out_a,     // Compare output A level
  output logic            compare_out_b,     // Compare output B level
  output logic            override_a,        // Compare output A owns its pin
  output logic            override_b         // Compare output B owns its pin
);

  typedef struct packed {
    logic [7:0] ctrl_a;   // Output modes and low waveform bits
    logic       top_sel;  // Third waveform select bit
    logic [7:0] cnt;      // Counter
    logic       up;       // Direction in phase-correct modes
    logic [7:0] compare_value_a_top;     // Active compare value A
    logic [7:0] ocrb;     // Active compare value B
    logic [7:0] rdata;    // Read data
    logic       ovf;      // Overflow pulse
    logic       cfa;      // Match A pulse
    logic       cfb;      // Match B pulse
    logic       ovr_a;    // Pin override A
    logic       ovr_b;    // Pin override B
  } tmrw_top_state_s;

  tmrw_top_state_s s_q;
  tmrw_top_state_s s_d;

  logic [2:0] wsel;
  tmrw_kind_e kind;
  logic [7:0] top_val;
  logic       hit_a;
  logic       hit_b;
  logic       at_top;
  logic       match_a;
  logic       match_b;
  logic       wrap_ev;
  logic       turn_top_ev;
  logic [1:0] chan_com    [2];
  logic       chan_match  [2];
  logic       chan_is_top [2];
  logic       chan_out    [2];

  // Mode decode from both control registers
  always_comb begin
    wsel    = {s_q.top_sel, s_q.ctrl_a[TMRW_WSEL_MID_POS], s_q.ctrl_a[TMRW_WSEL_LOW_POS]};
    kind    = tmrw_kind(wsel);
    top_val = tmrw_top_is_a(wsel) ? s_q.compare_value_a_top : TMRW_MAX;
    at_top  = (s_q.cnt == top_val);
  end

  // Address decode: each register answers at its data offset or its short I/O offset
  always_comb begin
    if (io_short) begin
      hit_a = (io_addr == TMRW_CTRL_A_IO);
      hit_b = (io_addr == TMRW_CTRL_B_IO);
    end else begin
      hit_a = (io_addr == TMRW_CTRL_A_OFS);
      hit_b = (io_addr == TMRW_CTRL_B_OFS);
    end
  end

  // Tick-qualified events; the tick never clocks anything by itself
  always_comb begin
    match_a     = timer_tick_enable && (s_q.cnt == s_q.compare_value_a_top);
    match_b     = timer_tick_enable && (s_q.cnt == s_q.ocrb);
    wrap_ev     = timer_tick_enable && (kind == TMRW_K_FAST) && at_top;
    turn_top_ev = timer_tick_enable && (kind == TMRW_K_PHASE) && s_q.up && at_top;
  end

  always_comb begin
    s_d     = s_q;
    s_d.ovf = 1'b0;
    s_d.cfa = match_a;
    s_d.cfb = match_b;

    // Register writes
    if (io_wr && hit_a) begin
      s_d.ctrl_a = io_wdata & TMRW_CTRL_A_MASK;
    end
    if (io_wr && hit_b) begin
      s_d.top_sel = io_wdata[TMRW_TOPSEL_POS];
    end

    // Register reads; unmapped addresses read zero
    if (io_rd && hit_a) begin
      s_d.rdata = s_q.ctrl_a;
    end else if (io_rd && hit_b) begin
      s_d.rdata = {4'h0, s_q.top_sel, 3'h0};
    end else if (io_rd) begin
      s_d.rdata = 8'h00;
    end

    // Pin takeover follows the stored output mode fields
    s_d.ovr_a = |s_d.ctrl_a[TMRW_CHA_HI_POS:TMRW_CHA_LO_POS];
    s_d.ovr_b = |s_d.ctrl_a[TMRW_CHB_HI_POS:TMRW_CHB_LO_POS];

    // Counting sequence per family
    case (kind)
      TMRW_K_CTC: begin
        s_d.up = 1'b1;
        if (timer_tick_enable) begin
          s_d.cnt = at_top ? TMRW_BOTTOM : s_q.cnt + TMRW_ONE;
          s_d.ovf = (s_q.cnt == TMRW_MAX);
        end
      end
      TMRW_K_FAST: begin
        s_d.up = 1'b1;
        if (timer_tick_enable) begin
          s_d.cnt = at_top ? TMRW_BOTTOM : s_q.cnt + TMRW_ONE;
          // TOP is MAX in mode 3, value A in mode 7
          s_d.ovf = at_top;
        end
      end
      TMRW_K_PHASE: begin
        if (timer_tick_enable) begin
          if (s_q.up) begin
            if (at_top) begin
              // Counter has shown TOP for this one tick; now turn round
              s_d.up  = 1'b0;
              s_d.cnt = s_q.cnt - TMRW_ONE;
            end else begin
              s_d.cnt = s_q.cnt + TMRW_ONE;
            end
          end else begin
            if (s_q.cnt == TMRW_BOTTOM) begin
              s_d.up  = 1'b1;
              s_d.cnt = s_q.cnt + TMRW_ONE;
              s_d.ovf = 1'b1;
            end else begin
              s_d.cnt = s_q.cnt - TMRW_ONE;
            end
          end
        end
      end
      default: begin
        // Reserved selections fall back on normal counting
        s_d.up = 1'b1;
        if (timer_tick_enable) begin
          s_d.cnt = s_q.cnt + TMRW_ONE;
          s_d.ovf = (s_q.cnt == TMRW_MAX);
        end
      end
    endcase

    // Compare value update point; buffering avoids glitched PWM periods
    case (kind)
      TMRW_K_FAST: begin
        if (wrap_ev) begin
          s_d.compare_value_a_top = compare_value_a;
          s_d.ocrb = compare_value_b;
        end
      end
      TMRW_K_PHASE: begin
        if (turn_top_ev) begin
          s_d.compare_value_a_top = compare_value_a;
          s_d.ocrb = compare_value_b;
        end
      end
      default: begin
        s_d.compare_value_a_top = compare_value_a;
        s_d.ocrb = compare_value_b;
      end
    endcase
  end

  // One clock for the whole block: I/O clock, or the timer oscillator when asynchronous
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s_q        <= '0;
      s_q.ctrl_a <= TMRW_CTRL_A_RST;
      s_q.top_sel <= TMRW_TOPSEL_RST;
      s_q.up     <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // Per-channel inputs; index 0 is channel A, index 1 is channel B
  always_comb begin
    chan_com[0]    = s_q.ctrl_a[TMRW_CHA_HI_POS:TMRW_CHA_LO_POS];
    chan_com[1]    = s_q.ctrl_a[TMRW_CHB_HI_POS:TMRW_CHB_LO_POS];
    chan_match[0]  = match_a;
    chan_match[1]  = match_b;
    chan_is_top[0] = (s_q.compare_value_a_top == top_val);
    chan_is_top[1] = (s_q.ocrb == top_val);
  end

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_chan
      tmrw_oc_chan #(
        .IS_CHAN_A (gi == 0)
      ) u_chan (
        .core_clk   (core_clk),
        .rstn       (rstn),
        .kind       (kind),
        .com        (chan_com[gi]),
        .top_sel    (s_q.top_sel),
        .match_ev   (chan_match[gi]),
        .bottom_ev  (wrap_ev),
        .top_ev     (turn_top_ev),
        .up         (s_q.up),
        .ocr_is_top (chan_is_top[gi]),
        .out        (chan_out[gi])
      );
    end
  endgenerate

  assign io_rdata       = s_q.rdata;
  assign count_value    = s_q.cnt;
  assign overflow_flag  = s_q.ovf;
  assign compare_flag_a = s_q.cfa;
  assign compare_flag_b = s_q.cfb;
  assign compare_out_a  = chan_out[0];
  assign compare_out_b  = chan_out[1];
  assign override_a     = s_q.ovr_a;
  assign override_b     = s_q.ovr_b;

endmodule : tmrw_wave_ctrl

`default_nettype wire

// file: verif/tmrw_wave_ctrl_props.sv
// Concurrent checks on the ports of the timer waveform control block
`timescale 1ns/100ps
`default_nettype none

module tmrw_wave_ctrl_props
  import tmrw_pkg::*;
(
  input wire logic       core_clk,          // Clock
  input wire logic       rstn,              // Reset, active low
  input wire logic [7:0] io_addr,           // Address
  input wire logic       io_short,          // Short space
  input wire logic [7:0] io_wdata,          // Write data
  input wire logic       io_wr,             // Write strobe
  input wire logic       io_rd,             // Read strobe
  input wire logic [7:0] io_rdata,          // Read data
  input wire logic       timer_tick_enable, // Tick
  input wire logic [7:0] compare_value_a,   // Value A
  input wire logic [7:0] compare_value_b,   // Value B
  input wire logic [7:0] count_value,       // Counter
  input wire logic       overflow_flag,     // Overflow pulse
  input wire logic       compare_flag_a,    // Match A pulse
  input wire logic       compare_flag_b,    // Match B pulse
  input wire logic       compare_out_a,     // Output A
  input wire logic       compare_out_b,     // Output B
  input wire logic       override_a,        // Pin A owned
  input wire logic       override_b         // Pin B owned
);
  logic [7:0] ctl_q;
  logic       top_q;
  logic       hit_a;
  logic       hit_b;
  logic [2:0] mode;

  // Shadow copy of the control bits, so each check knows the mode in force
  assign hit_a = io_addr == (io_short ? TMRW_CTRL_A_IO : TMRW_CTRL_A_OFS);
  assign hit_b = io_addr == (io_short ? TMRW_CTRL_B_IO : TMRW_CTRL_B_OFS);
  assign mode  = {top_q, ctl_q[1:0]};

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ctl_q <= 8'h00;
      top_q <= 1'b0;
    end else if (io_wr) begin
      if (hit_a)
        ctl_q <= io_wdata & TMRW_CTRL_A_MASK;
      if (hit_b)
        top_q <= io_wdata[TMRW_TOPSEL_POS];
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  ctl_read_a: assert property (io_rd && !io_wr && hit_a |=> io_rdata == ctl_q)
    else $error("control A read data wrong");
  pin_own_a: assert property (
    override_a == (ctl_q[7:6] != 2'h0) && override_b == (ctl_q[5:4] != 2'h0))
    else $error("pin ownership wrong");
  tick_gate_a: assert property (!timer_tick_enable |=> $stable(count_value)
    && !overflow_flag && !compare_flag_a && !compare_flag_b) else $error("change without tick");
  norm_wrap_a: assert property (mode == TMRW_WS_NORMAL && timer_tick_enable
    && count_value == TMRW_MAX |=> overflow_flag && count_value == TMRW_BOTTOM)
    else $error("normal wrap wrong");
  fast_wrap_a: assert property (mode == TMRW_WS_FAST_MAX && timer_tick_enable
    && count_value == TMRW_MAX |=> overflow_flag && count_value == TMRW_BOTTOM)
    else $error("fast wrap wrong");
  pc_top_a: assert property (mode == TMRW_WS_PC_MAX && timer_tick_enable
    && count_value == TMRW_MAX |=> count_value == 8'hFE && !overflow_flag)
    else $error("phase turn wrong");
  ctc_clr_a: assert property (mode == TMRW_WS_CTC && $stable(mode) && timer_tick_enable
    && count_value == compare_value_a && $stable(compare_value_a)
    |=> count_value == TMRW_BOTTOM && compare_flag_a) else $error("clear on match wrong");
  tog_out_a: assert property (mode == TMRW_WS_NORMAL && $stable(ctl_q) && compare_flag_a
    && ctl_q[7:6] == TMRW_COM_TOGGLE |-> compare_out_a != $past(compare_out_a))
    else $error("toggle output wrong");
  set_b_a: assert property (mode == TMRW_WS_NORMAL && $stable(ctl_q) && compare_flag_b
    && ctl_q[5:4] == TMRW_COM_SET |-> compare_out_b) else $error("output B set wrong");
endmodule : tmrw_wave_ctrl_props

bind tmrw_wave_ctrl tmrw_wave_ctrl_props chk_u (.core_clk, .rstn, .io_addr, .io_short,
  .io_wdata, .io_wr, .io_rd, .io_rdata, .timer_tick_enable, .compare_value_a,
  .compare_value_b, .count_value, .overflow_flag, .compare_flag_a, .compare_flag_b,
  .compare_out_a, .compare_out_b, .override_a, .override_b);

`default_nettype wire

// file: verif/tmrw_pin_model.sv
// Port pin model: the compare output takes the pin only while it owns it
`timescale 1ns/100ps
`default_nettype none

module tmrw_pin_model (
  input  wire logic ovr,      // Compare output owns pin
  input  wire logic oc,       // Compare output level
  input  wire logic dir_out,  // Direction bit, high drives
  input  wire logic port_val, // Normal port data
  output logic      pin       // Pin level
);
  // Undriven pin is pulled up, so ownership alone never shows the output
  always_comb begin
    if (!dir_out)
      pin = 1'b1;
    else if (ovr)
      pin = oc;
    else
      pin = port_val;
  end
endmodule : tmrw_pin_model

`default_nettype wire

// file: verif/timer_waveform_mode_control_bench.sv
// Self-checking bench for the timer waveform control block
`timescale 1ns/100ps
`default_nettype none

module timer_waveform_mode_control_bench
  import tmrw_pkg::*;
;
  logic       core_clk = 1'b0, rstn = 1'b0, io_short = 1'b0, io_wr = 1'b0, io_rd = 1'b0;
  logic       tk = 1'b0, ddr = 1'b1;
  logic [7:0] io_addr = 8'h00, io_wdata = 8'h00, va = 8'h00, vb = 8'h00;
  logic [7:0] io_rdata, cnt;
  logic       ovf, fa, fb, oa, ob, ova, ovb, pin_a;
  int         bad_count = 0, n_tests = 0, cyc = 0;

  always #12.5 core_clk = ~core_clk;

  tmrw_wave_ctrl dut_u (.core_clk, .rstn, .io_addr, .io_short, .io_wdata, .io_wr, .io_rd,
    .io_rdata, .timer_tick_enable(tk), .compare_value_a(va), .compare_value_b(vb),
    .count_value(cnt), .overflow_flag(ovf), .compare_flag_a(fa), .compare_flag_b(fb),
    .compare_out_a(oa), .compare_out_b(ob), .override_a(ova), .override_b(ovb));
  tmrw_pin_model pin_u (.ovr(ova), .oc(oa), .dir_out(ddr), .port_val(1'b0), .pin(pin_a));

  // The whole run needs about 5000 cycles
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      bad_count++;
      final_report();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic final_report();
    $display("Checks %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : final_report

  // Extra idle cycle keeps a strobe from being raised again in the same step
  task automatic wr(input logic [7:0] a, input logic s, input logic [7:0] w);
    io_addr = a;
    io_short = s;
    io_wdata = w;
    io_wr = 1'b1;
    @(negedge core_clk);
    io_wr = 1'b0;
    @(negedge core_clk);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic s, input logic [7:0] exp);
    io_addr = a;
    io_short = s;
    io_rd = 1'b1;
    @(negedge core_clk);
    io_rd = 1'b0;
    @(negedge core_clk);
    chk(io_rdata, exp);
  endtask : rdc

  task automatic setm(input logic [2:0] m, input logic [1:0] ca, input logic [1:0] cb);
    wr(TMRW_CTRL_B_OFS, 1'b0, {4'h0, m[2], 3'h0});
    wr(TMRW_CTRL_A_OFS, 1'b0, {ca, cb, 2'h0, m[1:0]});
  endtask : setm

  // Waits for overflow (0), match A (1) or match B (2)
  task automatic wt(input int sel);
    logic [2:0] f;
    for (int i = 0; i < 1200; i++) begin
      @(negedge core_clk);
      f = {ovf, fa, fb};
      if (f[2 - sel] === 1'b1)
        return;
    end
    chk(8'h00, 8'h01);
  endtask : wt

  task automatic t_regs();
    rdc(TMRW_CTRL_A_OFS, 1'b0, 8'h00);
    chk({ova, ovb}, 8'h00);
    wr(TMRW_CTRL_A_IO, 1'b1, 8'hFF);
    rdc(TMRW_CTRL_A_OFS, 1'b0, 8'hF3);
    chk({ova, ovb}, 8'h03);
    wr(TMRW_CTRL_A_OFS, 1'b1, 8'h00);
    rdc(TMRW_CTRL_A_IO, 1'b1, 8'hF3);
    wr(TMRW_CTRL_B_IO, 1'b1, 8'hFF);
    rdc(TMRW_CTRL_B_OFS, 1'b0, 8'h08);
    rdc(8'h46, 1'b0, 8'h00);
    chk(cnt, 8'h00);
    setm(TMRW_WS_NORMAL, TMRW_COM_OFF, TMRW_COM_OFF);
    $display("test regs done");
  endtask : t_regs

  task automatic t_nonpwm();
    logic p;
    va = 8'h05;
    vb = 8'h07;
    for (int c = 1; c < 4; c++) begin
      setm(TMRW_WS_NORMAL, c[1:0], c[1:0]);
      p = oa;
      wt(1);
      chk(oa, c == 1 ? !p : c[0]);
      chk(pin_a, oa);
      ddr = 1'b0;
      #1 chk(pin_a, 1'b1);
      ddr = 1'b1;
      p = ob;
      wt(2);
      chk(ob, c == 1 ? !p : c[0]);
    end
    va = 8'h30;
    setm(TMRW_WS_CTC, TMRW_COM_OFF, TMRW_COM_OFF);
    wt(1);
    chk(cnt, TMRW_BOTTOM);
    chk(pin_a, 8'h00);
    $display("test non-pwm done");
  endtask : t_nonpwm

  task automatic t_fast();
    logic p;
    va = 8'h10;
    vb = 8'h20;
    setm(TMRW_WS_FAST_MAX, TMRW_COM_CLEAR, TMRW_COM_SET);
    wt(0);
    wt(1);
    chk(oa, 1'b0);
    wt(2);
    chk(ob, 1'b1);
    wt(0);
    chk({oa, ob}, 8'h02);
    chk(cnt, TMRW_BOTTOM);
    setm(TMRW_WS_FAST_MAX, TMRW_COM_TOGGLE, TMRW_COM_TOGGLE);
    p = oa;
    wt(1);
    chk(oa, p);
    p = ob;
    wt(2);
    chk(ob, p);
    va = 8'h20;
    setm(TMRW_WS_FAST_A, TMRW_COM_TOGGLE, TMRW_COM_OFF);
    wt(0);
    p = oa;
    wt(1);
    chk(oa, !p);
    wt(0);
    chk(cnt, TMRW_BOTTOM);
    $display("test fast pwm done");
  endtask : t_fast

  task automatic t_phase();
    va = 8'h40;
    vb = 8'h80;
    setm(TMRW_WS_PC_MAX, TMRW_COM_CLEAR, TMRW_COM_SET);
    wt(0);
    chk(cnt, TMRW_ONE);
    wt(1);
    chk(oa, 1'b0);
    wt(2);
    chk(ob, 1'b1);
    wt(2);
    chk(ob, 1'b0);
    wt(1);
    chk(oa, 1'b1);
    // New TOP is only taken at a turn, so the second BOTTOM starts a clean period
    va = 8'h30;
    setm(TMRW_WS_PC_A, TMRW_COM_OFF, TMRW_COM_OFF);
    wt(0);
    wt(0);
    repeat (47) @(negedge core_clk);
    chk(cnt, 8'h30);
    @(negedge core_clk);
    chk(cnt, 8'h2F);
    $display("test phase pwm done");
  endtask : t_phase

  // Compare values at TOP: both outputs must sit high for a whole period
  task automatic t_edge(input logic [2:0] m);
    int e;
    e = 0;
    va = TMRW_MAX;
    vb = TMRW_MAX;
    setm(m, TMRW_COM_CLEAR, TMRW_COM_CLEAR);
    wt(0);
    wt(0);
    repeat (520) begin
      @(negedge core_clk);
      if ((oa & ob) !== 1'b1)
        e++;
    end
    chk((e > 255) ? 8'hFF : e[7:0], 8'h00);
    $display("test top edge done");
  endtask : t_edge

  initial begin
    repeat (8) @(negedge core_clk);
    rstn = 1'b1;
    t_regs();
    tk = 1'b1;
    t_nonpwm();
    t_fast();
    t_phase();
    t_edge(TMRW_WS_FAST_MAX);
    t_edge(TMRW_WS_PC_MAX);
    final_report();
  end
endmodule : timer_waveform_mode_control_bench

`default_nettype wire
